// ===== oflr_host.sv
`timescale 1ns/1ps
module oflr_host (
	input  wire logic        mclk_i,
	input  wire logic        rvalid_i,
	input  wire logic [15:0] rdata_i,
	output logic             wr_o,
	output logic             rd_o,
	output logic      [7:0]  cmd_o,
	output logic      [15:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		cmd_o = 8'h00;
		wdata_o = 16'h0000;
	end

	// Released lines show the inverse so stale values never look valid
	task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
		@(posedge mclk_i);
		wr_o <= 1'b1;
		cmd_o <= c;
		wdata_o <= d;
		@(posedge mclk_i);
		wr_o <= 1'b0;
		cmd_o <= ~c;
		wdata_o <= ~d;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] c, output logic [15:0] d);
		int k;
		@(posedge mclk_i);
		rd_o <= 1'b1;
		cmd_o <= c;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		cmd_o <= ~c;
		k = 0;
		do begin
			@(posedge mclk_i);
			k++;
		end while (rvalid_i !== 1'b1 && k < 4);
		// Timed-out read returns unknown so the compare fails
		d = (rvalid_i === 1'b1) ? rdata_i : 16'hXXXX;
	endtask : rd_reg
endmodule : oflr_host

// ===== oflr_pkg.sv
package oflr_pkg;

	// Command codes of the limit and action registers
	localparam logic [7:0]  CMD_UV_FLT_LIM  = 8'h44;
	localparam logic [7:0]  CMD_UV_FLT_ACT  = 8'h45;
	localparam logic [7:0]  CMD_OC_FLT_LIM  = 8'h46;
	localparam logic [7:0]  CMD_OC_FLT_ACT  = 8'h47;
	localparam logic [7:0]  CMD_OC_WRN_LIM  = 8'h4A;
	localparam logic [7:0]  CMD_OT_FLT_LIM  = 8'h4F;
	localparam logic [7:0]  CMD_OT_FLT_ACT  = 8'h50;
	localparam logic [7:0]  CMD_OT_WRN_LIM  = 8'h51;

	// Power-up values, as loaded from nonvolatile memory
	localparam logic [15:0] UV_FLT_LIM_RST  = 16'h00F5;
	localparam logic [7:0]  UV_FLT_ACT_RST  = 8'hB9;
	localparam logic [7:0]  OC_FLT_ACT_RST  = 8'hA1;
	localparam logic [15:0] OT_FLT_LIM_RST  = 16'h007D;
	localparam logic [7:0]  OT_FLT_ACT_RST  = 8'hF9;
	localparam logic [15:0] OT_WRN_LIM_RST  = 16'h0069;

	// Action codes with their own behaviour
	localparam logic [7:0]  ACT_IGNORE      = 8'h00;
	localparam logic [7:0]  ACT_RETRY       = 8'hB9;
	localparam logic [7:0]  ACT_HICCUP      = 8'hA1;
	localparam logic [7:0]  ACT_WHILE       = 8'hF9;
	localparam logic [7:0]  ACT_WHILE_STD   = 8'hF8;

	// Timing
	localparam int unsigned RESTART_DELAY_MS = 20;
	localparam int unsigned CLK_FREQ_KHZ     = 200000;
	localparam int unsigned RESTART_DELAY_CYC = RESTART_DELAY_MS * CLK_FREQ_KHZ;
	localparam int unsigned OC_TRIP_CYCLES   = 128;

	typedef enum logic [4:0] {
		K_IGNORE = 5'b00001,
		K_LATCH  = 5'b00010,
		K_RETRY  = 5'b00100,
		K_HICCUP = 5'b01000,
		K_WHILE  = 5'b10000
	} oflr_kind_t;

	typedef enum logic [4:0] {
		ST_OFF   = 5'b00001,
		ST_RUN   = 5'b00010,
		ST_WAIT  = 5'b00100,
		ST_HOLD  = 5'b01000,
		ST_LATCH = 5'b10000
	} oflr_state_t;

	// Fault cause bits
	localparam int unsigned CAUSE_OT = 2;
	localparam int unsigned CAUSE_UV = 1;
	localparam int unsigned CAUSE_OC = 0;

	function automatic oflr_kind_t oflr_decode(input logic [7:0] code);
		oflr_kind_t k;
		k = K_LATCH;
		if (code == ACT_IGNORE) begin
			k = K_IGNORE;
		end else if (code == ACT_RETRY) begin
			k = K_RETRY;
		end else if (code == ACT_HICCUP) begin
			k = K_HICCUP;
		end else if (code == ACT_WHILE || code == ACT_WHILE_STD) begin
			k = K_WHILE;
		end
		return k;
	endfunction : oflr_decode

endpackage : oflr_pkg

// ===== oflr_sync.sv
`timescale 1ns/1ps
module oflr_sync (
	input  wire logic mclk_i,
	input  wire logic resetn_i,
	input  wire logic async_i,
	output logic      level_o,
	output logic      rise_o
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg;
	wire  agree = (s2_reg == s3_reg);

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1_reg  <= 1'b0;
			s2_reg  <= 1'b0;
			s3_reg  <= 1'b0;
			lvl_reg <= 1'b0;
		end else begin
			s1_reg <= async_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (agree) begin
				lvl_reg <= s3_reg;
			end
		end
	end

	assign level_o = lvl_reg;
	assign rise_o  = agree & s3_reg & ~lvl_reg;
endmodule : oflr_sync

// ===== oflr_top.sv
`timescale 1ns/1ps
// Functional notes
// - Under-voltage with code B9h: output off, wait 20 ms, restart, retry forever.
// - Retrying stops when commanded off or an over-temperature fault, unless it is the cause, forces shutdown.
// - Code A1h: keep switching, shut down after 128 consecutive over-current cycles.
// - After over-current shutdown wait 20 ms, restart; repeat while over-current persists.
// - Over-current code A1h decodes as its own legal action.
// - Over-temperature code F9h: output held off while over-temperature lasts.
// - Code F9h: output resumes by itself once over-temperature clears.
module oflr_top
	import oflr_pkg::*;
#(
	parameter int unsigned     RESTART_CYC    = RESTART_DELAY_CYC,
	parameter int unsigned     OC_CYCLES      = OC_TRIP_CYCLES,
	parameter logic [15:0]     OC_FLT_LIM_RST = 16'h7FFF,
	parameter logic [15:0]     OC_WRN_LIM_RST = 16'h7FFF
) (
	input  wire logic          mclk_i,
	input  wire logic          resetn_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	input  wire logic [7:0]    cmd_i,
	input  wire logic [15:0]   wdata_i,
	output logic      [15:0]   rdata_o,
	output logic               rvalid_o,
	output logic               rhit_o,
	input  wire logic          enable_pin_i,
	input  wire logic          operation_on_i,
	input  wire logic          sw_clk_i,
	input  wire logic [15:0]   vout_i,
	input  wire logic [15:0]   iout_i,
	input  wire logic [15:0]   temp_i,
	output logic               output_enable_o,
	output logic               uv_fault_o,
	output logic               oc_fault_o,
	output logic               ot_fault_o,
	output logic               oc_warn_o,
	output logic               ot_warn_o
);
	localparam int CW = (OC_CYCLES > 2) ? $clog2(OC_CYCLES) : 1;

	generate
		if (RESTART_CYC < 1 || OC_CYCLES < 2) begin : g_bad
			$error("oflr_top: RESTART_CYC must be >= 1 and OC_CYCLES >= 2");
		end
	endgenerate

	logic [15:0]   uv_lim_reg;
	logic [7:0]    uv_act_reg;
	logic [15:0]   oc_lim_reg;
	logic [7:0]    oc_act_reg;
	logic [15:0]   oc_wrn_reg;
	logic [15:0]   ot_lim_reg;
	logic [7:0]    ot_act_reg;
	logic [15:0]   ot_wrn_reg;
	oflr_state_t   state_reg;
	oflr_state_t   state_next;
	logic [2:0]    cause_reg;
	logic [2:0]    cause_next;
	logic [CW-1:0] oc_cnt_reg;
	logic [31:0]   dly_reg;
	logic [15:0]   rdata_reg;
	logic          rvalid_reg;
	logic          rhit_reg;
	logic [4:0]    flag_reg;
	logic          en_lvl;
	logic          sw_rise;

	oflr_sync u_en_sync (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.async_i  (enable_pin_i),
		.level_o  (en_lvl),
		.rise_o   ()
	);

	oflr_sync u_sw_sync (
		.mclk_i   (mclk_i),
		.resetn_i (resetn_i),
		.async_i  (sw_clk_i),
		.level_o  (),
		.rise_o   (sw_rise)
	);

	// Limit comparisons
	wire        cmd_on    = en_lvl & operation_on_i;
	wire        uv_flt    = vout_i < uv_lim_reg;
	wire        oc_flt    = iout_i > oc_lim_reg;
	wire        ot_flt    = temp_i > ot_lim_reg;
	wire        oc_wrn    = iout_i > oc_wrn_reg;
	wire        ot_wrn    = temp_i > ot_wrn_reg;
	oflr_kind_t uv_kind;
	oflr_kind_t oc_kind;
	oflr_kind_t ot_kind;
	assign uv_kind = oflr_decode(uv_act_reg);
	assign oc_kind = oflr_decode(oc_act_reg);
	assign ot_kind = oflr_decode(ot_act_reg);

	wire        oc_last   = oc_cnt_reg == CW'(OC_CYCLES - 1);
	wire        ot_req    = ot_flt && ot_kind != K_IGNORE;
	wire        uv_req    = uv_flt && uv_kind != K_IGNORE;
	wire        oc_req    = oc_flt && ((oc_kind == K_HICCUP) ? (sw_rise && oc_last) : (oc_kind != K_IGNORE));
	wire        any_req   = ot_req | uv_req | oc_req;
	wire [2:0]  sel_cause = ot_req ? 3'h4 : (uv_req ? 3'h2 : (oc_req ? 3'h1 : 3'h0));
	oflr_kind_t sel_kind;
	assign sel_kind = ot_req ? ot_kind : (uv_req ? uv_kind : oc_kind);
	wire        dly_done  = dly_reg == 32'(RESTART_CYC - 1);
	wire        cause_gone = (cause_reg & {ot_flt, uv_flt, oc_flt}) == 3'h0;
	wire        other_req = ot_req && !cause_reg[CAUSE_OT];

	always_comb begin
		state_next = state_reg;
		cause_next = cause_reg;
		unique case (state_reg)
			ST_OFF: begin
				if (cmd_on) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!cmd_on) begin
					state_next = ST_OFF;
				end else if (any_req) begin
					cause_next = sel_cause;
					if (sel_kind == K_RETRY || sel_kind == K_HICCUP) begin
						state_next = ST_WAIT;
					end else if (sel_kind == K_WHILE) begin
						state_next = ST_HOLD;
					end else begin
						state_next = ST_LATCH;
					end
				end
			end
			ST_WAIT: begin
				if (!cmd_on) begin
					state_next = ST_OFF;
				end else if (other_req) begin
					state_next = ST_LATCH;
				end else if (dly_done) begin
					state_next = ST_RUN;
				end
			end
			ST_HOLD: begin
				if (!cmd_on) begin
					state_next = ST_OFF;
				end else if (cause_gone) begin
					state_next = ST_RUN;
				end
			end
			ST_LATCH: begin
				if (!cmd_on) begin
					state_next = ST_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= ST_OFF;
			cause_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			cause_reg <= cause_next;
		end
	end

	// Consecutive over-current switching cycles
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			oc_cnt_reg <= '0;
		end else if (state_reg != ST_RUN) begin
			oc_cnt_reg <= '0;
		end else if (sw_rise) begin
			oc_cnt_reg <= oc_flt ? CW'(oc_cnt_reg + 1'b1) : '0;
		end
	end

	// Restart delay
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dly_reg <= 32'h0;
		end else begin
			dly_reg <= (state_reg == ST_WAIT) ? 32'(dly_reg + 1'b1) : 32'h0;
		end
	end

	// Register bank writes
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			uv_lim_reg <= UV_FLT_LIM_RST;
			uv_act_reg <= UV_FLT_ACT_RST;
			oc_lim_reg <= OC_FLT_LIM_RST;
			oc_act_reg <= OC_FLT_ACT_RST;
			oc_wrn_reg <= OC_WRN_LIM_RST;
			ot_lim_reg <= OT_FLT_LIM_RST;
			ot_act_reg <= OT_FLT_ACT_RST;
			ot_wrn_reg <= OT_WRN_LIM_RST;
		end else if (wr_i) begin
			if (cmd_i == CMD_UV_FLT_LIM) uv_lim_reg <= wdata_i;
			if (cmd_i == CMD_UV_FLT_ACT) uv_act_reg <= wdata_i[7:0];
			if (cmd_i == CMD_OC_FLT_LIM) oc_lim_reg <= wdata_i;
			if (cmd_i == CMD_OC_FLT_ACT) oc_act_reg <= wdata_i[7:0];
			if (cmd_i == CMD_OC_WRN_LIM) oc_wrn_reg <= wdata_i;
			if (cmd_i == CMD_OT_FLT_LIM) ot_lim_reg <= wdata_i;
			if (cmd_i == CMD_OT_FLT_ACT) ot_act_reg <= wdata_i[7:0];
			if (cmd_i == CMD_OT_WRN_LIM) ot_wrn_reg <= wdata_i;
		end
	end

	// Read selection; unmapped codes read zero with hit low
	wire        rd_map = (cmd_i == CMD_UV_FLT_LIM) || (cmd_i == CMD_UV_FLT_ACT) || (cmd_i == CMD_OC_FLT_LIM)
	                  || (cmd_i == CMD_OC_FLT_ACT) || (cmd_i == CMD_OC_WRN_LIM) || (cmd_i == CMD_OT_FLT_LIM)
	                  || (cmd_i == CMD_OT_FLT_ACT) || (cmd_i == CMD_OT_WRN_LIM);
	wire [15:0] rd_mux = (cmd_i == CMD_UV_FLT_LIM) ? uv_lim_reg :
	                     (cmd_i == CMD_UV_FLT_ACT) ? {8'h00, uv_act_reg} :
	                     (cmd_i == CMD_OC_FLT_LIM) ? oc_lim_reg :
	                     (cmd_i == CMD_OC_FLT_ACT) ? {8'h00, oc_act_reg} :
	                     (cmd_i == CMD_OC_WRN_LIM) ? oc_wrn_reg :
	                     (cmd_i == CMD_OT_FLT_LIM) ? ot_lim_reg :
	                     (cmd_i == CMD_OT_FLT_ACT) ? {8'h00, ot_act_reg} :
	                     (cmd_i == CMD_OT_WRN_LIM) ? ot_wrn_reg : 16'h0000;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_reg  <= 16'h0000;
			rvalid_reg <= 1'b0;
			rhit_reg   <= 1'b0;
			flag_reg   <= 5'h00;
		end else begin
			rvalid_reg <= rd_i;
			if (rd_i) begin
				rdata_reg <= rd_mux;
				rhit_reg  <= rd_map;
			end
			flag_reg <= {uv_flt, oc_flt, ot_flt, oc_wrn, ot_wrn};
		end
	end

	assign rdata_o         = rdata_reg;
	assign rvalid_o        = rvalid_reg;
	assign rhit_o          = rhit_reg;
	assign output_enable_o = state_reg == ST_RUN;
	assign uv_fault_o      = flag_reg[4];
	assign oc_fault_o      = flag_reg[3];
	assign ot_fault_o      = flag_reg[2];
	assign oc_warn_o       = flag_reg[1];
	assign ot_warn_o       = flag_reg[0];

	property p_uv_retry;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_reg == ST_RUN && cmd_on && uv_req && !ot_req && uv_kind == K_RETRY) |=> (state_reg == ST_WAIT && !output_enable_o);
	endproperty
	a_uv_retry: assert property (p_uv_retry) else $error("uv retry did not shut down");
	property p_off_stops;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_reg == ST_WAIT && !cmd_on) |=> (state_reg == ST_OFF);
	endproperty
	a_off_stops: assert property (p_off_stops) else $error("retry not stopped by command off");
	property p_other_stops;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_reg == ST_WAIT && cmd_on && other_req) |=> (state_reg == ST_LATCH) ##1 !output_enable_o;
	endproperty
	a_other_stops: assert property (p_other_stops) else $error("retry not stopped by other fault");
	property p_oc_count;
		@(posedge mclk_i) disable iff (!resetn_i)
		$rose(state_reg == ST_WAIT) && cause_reg == 3'h1 && oc_kind == K_HICCUP |-> $past(oc_cnt_reg) == CW'(OC_CYCLES - 1);
	endproperty
	a_oc_count: assert property (p_oc_count) else $error("over-current trip not at full count");
	property p_restart;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_reg == ST_WAIT && dly_done && cmd_on && !other_req) |=> output_enable_o;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart after delay");
	property p_wait_len;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_reg == ST_RUN && $past(state_reg) == ST_WAIT) |-> $past(dly_done);
	endproperty
	a_wait_len: assert property (p_wait_len) else $error("left restart wait before delay end");
	property p_no_early;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_reg == ST_WAIT && !dly_done && cmd_on) |=> (state_reg != ST_RUN);
	endproperty
	a_no_early: assert property (p_no_early) else $error("restart before delay end");
	property p_a1_legal;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_reg == ST_RUN && cmd_on && oc_act_reg == ACT_HICCUP && oc_flt && !oc_last && !ot_req && !uv_req)
			|=> output_enable_o;
	endproperty
	a_a1_legal: assert property (p_a1_legal) else $error("A1h over-current stopped before full count");
	property p_ot_hold;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_reg == ST_HOLD && cause_reg[CAUSE_OT] && ot_flt) |=> !output_enable_o;
	endproperty
	a_ot_hold: assert property (p_ot_hold) else $error("output on during over-temperature");
	property p_ot_resume;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_reg == ST_HOLD && cause_reg == 3'h4 && !ot_flt && cmd_on) |=> output_enable_o;
	endproperty
	a_ot_resume: assert property (p_ot_resume) else $error("no resume after over-temperature");
	property p_warn_runs;
		@(posedge mclk_i) disable iff (!resetn_i)
		(state_reg == ST_RUN && cmd_on && !any_req && (oc_wrn || ot_wrn))
			|=> output_enable_o && oc_warn_o == $past(oc_wrn) && ot_warn_o == $past(ot_wrn);
	endproperty
	a_warn_runs: assert property (p_warn_runs) else $error("warning stopped the output");

	c_uv_retry: cover property (@(posedge mclk_i) disable iff (!resetn_i) state_reg == ST_WAIT && cause_reg == 3'h2 ##1 state_reg == ST_RUN);
	c_oc_hiccup: cover property (@(posedge mclk_i) disable iff (!resetn_i) state_reg == ST_RUN && oc_req && oc_kind == K_HICCUP);
	c_ot_resume: cover property (@(posedge mclk_i) disable iff (!resetn_i) state_reg == ST_HOLD ##1 state_reg == ST_RUN);
	c_latch: cover property (@(posedge mclk_i) disable iff (!resetn_i) state_reg == ST_LATCH);
endmodule : oflr_top

// ===== tb_oflr_top.sv
`timescale 1ns/1ps
module tb_oflr_top;
	import oflr_pkg::*;
	localparam int RC  = 40;
	localparam int OCN = 4;
	localparam logic [7:0]  CMDS [8] = '{CMD_UV_FLT_LIM, CMD_UV_FLT_ACT, CMD_OC_FLT_LIM, CMD_OC_FLT_ACT,
		CMD_OC_WRN_LIM, CMD_OT_FLT_LIM, CMD_OT_FLT_ACT, CMD_OT_WRN_LIM};
	localparam logic [15:0] RSTV [8] = '{UV_FLT_LIM_RST, {8'h00, UV_FLT_ACT_RST}, 16'h7FFF,
		{8'h00, OC_FLT_ACT_RST}, 16'h7FFF, OT_FLT_LIM_RST, {8'h00, OT_FLT_ACT_RST}, OT_WRN_LIM_RST};
	localparam logic [15:0] MSK [8] = '{16'hFFFF, 16'h00FF, 16'hFFFF, 16'h00FF,
		16'hFFFF, 16'hFFFF, 16'h00FF, 16'hFFFF};
	logic        mclk_i, resetn_i, enable_pin_i, operation_on_i, sw_clk_i;
	logic        wr_i, rd_i, rvalid_o, rhit_o, output_enable_o;
	logic        uv_fault_o, oc_fault_o, ot_fault_o, oc_warn_o, ot_warn_o;
	logic [7:0]  cmd_i;
	logic [15:0] wdata_i, rdata_o, vout_i, iout_i, temp_i, v, w;
	int          fails, checks_done, cyc, n;

	oflr_top #(.RESTART_CYC(RC), .OC_CYCLES(OCN)) oflr_top_inst (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .wr_i(wr_i), .rd_i(rd_i), .cmd_i(cmd_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .rhit_o(rhit_o),
		.enable_pin_i(enable_pin_i), .operation_on_i(operation_on_i), .sw_clk_i(sw_clk_i),
		.vout_i(vout_i), .iout_i(iout_i), .temp_i(temp_i), .output_enable_o(output_enable_o),
		.uv_fault_o(uv_fault_o), .oc_fault_o(oc_fault_o), .ot_fault_o(ot_fault_o),
		.oc_warn_o(oc_warn_o), .ot_warn_o(ot_warn_o));
	oflr_host oflr_host_inst (.mclk_i(mclk_i), .rvalid_i(rvalid_o), .rdata_i(rdata_o),
		.wr_o(wr_i), .rd_o(rd_i), .cmd_o(cmd_i), .wdata_o(wdata_i));

	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	// Switching clock, free running, phase unrelated to mclk_i
	initial begin
		sw_clk_i = 1'b0;
		#7.3;
		forever #40 sw_clk_i = ~sw_clk_i;
	end

	task automatic stop_test();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic chkb(input logic seen, input logic exp);
		chk({15'h0000, seen}, {15'h0000, exp});
	endtask : chkb

	task automatic wait_en(input logic val, input int lim, output int cnt);
		cnt = 0;
		while (output_enable_o !== val && cnt < lim) begin
			@(negedge mclk_i);
			cnt++;
		end
	endtask : wait_en

	task automatic hold(input logic val, input int len);
		int k;
		k = 0;
		repeat (len) begin
			@(negedge mclk_i);
			if (output_enable_o === val) k++;
		end
		chk(16'(k), 16'(len));
	endtask : hold

	function automatic logic [15:0] v_ok();
		return 16'h0100 + 16'($urandom_range(0, 16'h0F00));
	endfunction : v_ok

	function automatic logic [15:0] v_low();
		return 16'($urandom_range(0, 16'h00F4));
	endfunction : v_low

	function automatic logic [15:0] t_hot();
		return 16'($urandom_range(16'h007E, 16'h00FF));
	endfunction : t_hot

	initial begin
		void'($urandom(32'h565eafa8));
		resetn_i = 1'b0;
		enable_pin_i = 1'b0;
		operation_on_i = 1'b0;
		vout_i = 16'h0200;
		iout_i = 16'h0100;
		temp_i = 16'h0040;
		repeat (8) @(posedge mclk_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			oflr_host_inst.rd_reg(CMDS[i], v);
			chk(v, RSTV[i]);
			chkb(rhit_o, 1'b1);
		end
		oflr_host_inst.wr_reg(8'h48, 16'h1234);
		oflr_host_inst.rd_reg(8'h48, v);
		chk(v, 16'h0000);
		chkb(rhit_o, 1'b0);
		for (int i = 0; i < 8; i++) begin
			w = 16'($urandom);
			oflr_host_inst.wr_reg(CMDS[i], w);
			oflr_host_inst.rd_reg(CMDS[i], v);
			chk(v, w & MSK[i]);
			oflr_host_inst.wr_reg(CMDS[i], RSTV[i]);
		end
		oflr_host_inst.wr_reg(CMD_OC_FLT_LIM, 16'h1000);
		oflr_host_inst.wr_reg(CMD_OC_WRN_LIM, 16'h0800);
		@(posedge mclk_i);
		enable_pin_i <= 1'b1;
		operation_on_i <= 1'b1;
		vout_i <= v_ok();
		wait_en(1'b1, 20, n);
		chkb(output_enable_o, 1'b1);
		// Under-voltage retry, twice with the fault still present
		@(posedge mclk_i);
		vout_i <= v_low();
		repeat (2) begin
			wait_en(1'b0, 5, n);
			chkb(uv_fault_o, 1'b1);
			wait_en(1'b1, RC + 10, n);
			chk(16'(n), 16'(RC));
		end
		// Third trip comes at once; clear the fault during its wait
		wait_en(1'b0, 5, n);
		@(posedge mclk_i);
		vout_i <= v_ok();
		wait_en(1'b1, RC + 10, n);
		chk(16'(n), 16'(RC));
		hold(1'b1, 3 * RC);
		// Commanded off while waiting to restart
		@(posedge mclk_i);
		vout_i <= v_low();
		wait_en(1'b0, 5, n);
		@(posedge mclk_i);
		operation_on_i <= 1'b0;
		vout_i <= v_ok();
		hold(1'b0, 2 * RC);
		@(posedge mclk_i);
		operation_on_i <= 1'b1;
		wait_en(1'b1, 10, n);
		chkb(output_enable_o, 1'b1);
		// Over-temperature during the restart wait latches off
		@(posedge mclk_i);
		vout_i <= v_low();
		wait_en(1'b0, 5, n);
		@(posedge mclk_i);
		temp_i <= t_hot();
		vout_i <= v_ok();
		repeat (5) @(posedge mclk_i);
		temp_i <= 16'h0040;
		hold(1'b0, 2 * RC);
		@(posedge mclk_i);
		enable_pin_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		enable_pin_i <= 1'b1;
		wait_en(1'b1, 20, n);
		chkb(output_enable_o, 1'b1);
		// Over-temperature off while present, back on at the limit itself
		@(posedge mclk_i);
		temp_i <= t_hot();
		wait_en(1'b0, 5, n);
		chkb(ot_fault_o, 1'b1);
		hold(1'b0, 2 * RC);
		@(posedge mclk_i);
		temp_i <= OT_FLT_LIM_RST;
		wait_en(1'b1, 5, n);
		chkb(output_enable_o, 1'b1);
		chkb(ot_warn_o, 1'b1);
		chkb(ot_fault_o, 1'b0);
		hold(1'b1, RC);
		// Over-current at the limit only warns
		@(posedge mclk_i);
		temp_i <= 16'h0040;
		iout_i <= 16'h1000;
		hold(1'b1, 48);
		chkb(oc_warn_o, 1'b1);
		chkb(oc_fault_o, 1'b0);
		@(posedge sw_clk_i);
		repeat (6) @(posedge mclk_i);
		iout_i <= 16'h1001 + 16'($urandom_range(0, 16'h0FFF));
		repeat (OCN - 1) @(posedge sw_clk_i);
		repeat (10) @(negedge mclk_i);
		chkb(output_enable_o, 1'b1);
		@(posedge sw_clk_i);
		wait_en(1'b0, 12, n);
		chkb(output_enable_o, 1'b0);
		wait_en(1'b1, RC + 10, n);
		chk(16'(n), 16'(RC));
		wait_en(1'b0, OCN * 16 + 24, n);
		chkb(output_enable_o, 1'b0);
		@(posedge mclk_i);
		iout_i <= 16'h0100;
		wait_en(1'b1, RC + 10, n);
		hold(1'b1, 128);
		// Ignore code leaves the output running under over-current
		oflr_host_inst.wr_reg(CMD_OC_FLT_ACT, {8'h00, ACT_IGNORE});
		@(posedge mclk_i);
		iout_i <= 16'h2000;
		hold(1'b1, 128);
		chkb(oc_fault_o, 1'b1);
		// Reset in mid-run restores defaults and clears outputs
		@(posedge mclk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		chkb(output_enable_o, 1'b0);
		chkb(oc_fault_o, 1'b0);
		resetn_i <= 1'b1;
		oflr_host_inst.rd_reg(CMD_OC_FLT_ACT, v);
		chk(v, {8'h00, OC_FLT_ACT_RST});
		stop_test();
	end
endmodule : tb_oflr_top
